// ===== bench/plc_chk.sv
// plc_chk: port assertions of the characterizer.
// assumes it is bound into plc_characterizer, one clock domain.
`timescale 1ns/1ps
module plc_chk #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_re,
  input wire logic [plc_pkg::PLC_DW-1:0] reg_rdata,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic signed [W-1:0] out1,
  input wire logic signed [W-1:0] out2,
  input wire logic out_valid,
  input wire logic [1:0] mode,
  input wire logic cfg_err
);
  import plc_pkg::*;
  // ========
  // one clock, so one default clocking and reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // read data stand one cycle only
  rd_idle_a: assert property (!$past(reg_re) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  check_first_a: assert property (
    in_valid && in_ready |=> !in_ready [*8])
    else $error("run ended before the check stage");
  run_bound_a: assert property (
    in_valid && in_ready |-> ##[2:160] in_ready)
    else $error("run did not finish in time");
  pulse_one_a: assert property (out_valid |=> !out_valid)
    else $error("result strobe longer than one cycle");
  no_err_out_a: assert property (out_valid |-> in_ready && !cfg_err)
    else $error("result given with a curve error");
  oos_quiet_a: assert property (out_valid |-> mode != PLC_MODE_OOS)
    else $error("result given out of service");
  err_oos_a: assert property (
    cfg_err && in_ready |-> mode == PLC_MODE_OOS)
    else $error("curve error without out of service");
  // outputs only move together with the strobe
  out_hold_a: assert property (
    !out_valid |-> $stable(out1) && $stable(out2))
    else $error("outputs moved without strobe");
endmodule // plc_chk

bind plc_characterizer plc_chk #(.W(W)) i_plc_chk (.clock(clock),
  .srst(srst), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .in_valid(in_valid), .in_ready(in_ready), .out1(out1), .out2(out2),
  .out_valid(out_valid), .mode(mode), .cfg_err(cfg_err));

// ===== bench/plc_src.sv
// plc_src: upstream block model feeding both channel inputs.
// assumes go is a one-cycle request from the bench.
`timescale 1ns/1ps
module plc_src (
  input wire logic clock,
  input wire logic srst,
  input wire logic go,
  input wire logic signed [15:0] a,
  input wire logic signed [15:0] b,
  input wire logic in_ready,
  output logic in_valid = 1'b0,
  output logic signed [15:0] in1 = '0,
  output logic signed [15:0] in2 = '0
);
  // ========
  // hold the sample until taken, then scramble it
  always @(posedge clock)
  begin
    if (srst)
      in_valid <= 1'b0;
    else if (in_valid && in_ready)
    begin
      in_valid <= 1'b0;
      in1 <= ~in1; // stale sample must not look valid
      in2 <= ~in2;
    end
    else if (go)
    begin
      in_valid <= 1'b1;
      in1 <= a;
      in2 <= b;
    end
  end
endmodule // plc_src

// ===== bench/tb.sv
// tb: self-checking bench of the characterizer.
// assumes plc_src as upstream block and a 40 MHz clock.
`timescale 1ns/1ps
module tb;
  import plc_pkg::*;
  logic clock = 0;
  logic srst = 1;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_we = 0;
  logic reg_re = 0;
  logic go = 0;
  logic [31:0] reg_rdata, d;
  logic irq, in_valid, in_ready, out_valid, cfg_err, seen;
  logic signed [15:0] in1, in2, out1, out2, a_r = '0, b_r = '0;
  logic [1:0] mode;
  int n_fail = 0;
  int samples_checked = 0;
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  plc_characterizer i_plc_characterizer (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
    .in_valid(in_valid), .in1(in1), .in2(in2), .in_ready(in_ready),
    .out1(out1), .out2(out2), .out_valid(out_valid), .mode(mode),
    .cfg_err(cfg_err));
  plc_src i_plc_src (.clock(clock), .srst(srst), .go(go), .a(a_r),
    .b(b_r), .in_ready(in_ready), .in_valid(in_valid), .in1(in1),
    .in2(in2));
  // ========
  // verdict and checks
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // interpolation truncates, so one LSB low is accepted
  task automatic chk_s(input logic signed [15:0] g,
                       input logic signed [15:0] e);
    samples_checked++;
    if (g !== e && g !== e - 16'sd1)
    begin
      n_fail++;
      $display("Error %0t: out %0d want %0d", $time, g, e);
    end
  endtask
  // ========
  // register port and sample run
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic run(input logic signed [15:0] a, input logic signed [15:0] b);
    int k;
    @(posedge clock);
    a_r <= a;
    b_r <= b;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    seen = 1'b0;
    for (k = 0; k < 400; k++)
    begin
      @(posedge clock);
      #1;
      if (out_valid === 1'b1) seen = 1'b1;
      if (in_ready === 1'b1 && !in_valid) break;
    end
    if (k == 400)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  // ========
  // scenarios
  task automatic t_regs();
    rd(PLC_STATUS);
    chk_v(d, 32'h0);
    rd(PLC_IRQ_MASK);
    chk_v(d, 32'h0);
    rd(8'h3c); // unmapped place reads zero
    chk_v(d, 32'h0);
    wr(PLC_MAN1, 32'hffff0123);
    rd(PLC_MAN1);
    chk_v(d, 32'h00000123);
  endtask
  task automatic t_empty();
    run(16'sd1, 16'sd1);
    chk_v(seen, 0);
    chk_v({cfg_err, mode}, 3'h4);
  endtask
  task automatic t_curve();
    wr(PLC_X_BASE + 8'h04, 32'd100);
    wr(PLC_X_BASE + 8'h08, 32'd200);
    // points chosen so every slope is exact in fixed point
    wr(PLC_Y_BASE + 8'h04, 32'd400);
    wr(PLC_Y_BASE + 8'h08, 32'd1200);
    wr(PLC_X_BASE, 32'd0);
    wr(PLC_Y_BASE, 32'd0);
    rd(PLC_X_BASE + 8'h40); // unwritten x point 16 still reads plus infinity
    chk_v(d, 32'h7fff);
    wr(PLC_CTRL, 32'h2);
    run(16'sd50, 16'sd150);
    chk_v(seen, 1);
    chk_s(out1, 16'sd200);
    chk_s(out2, 16'sd800);
    run(-16'sd5, 16'sd300);
    chk_s(out1, 16'sd0);
    chk_s(out2, 16'sd1200);
    wr(PLC_CTRL, 32'h6);
    run(16'sd25, 16'sd800);
    chk_s(out1, 16'sd100);
    chk_s(out2, 16'sd150);
    run(16'sd0, 16'sd9999);
    chk_s(out2, 16'sd200);
  endtask
  task automatic t_mono();
    wr(PLC_Y_BASE + 8'h08, 32'd300);
    run(16'sd150, 16'sd150);
    chk_v({seen, cfg_err}, 2'h1);
    wr(PLC_CTRL, 32'h2);
    run(16'sd150, 16'sd150);
    chk_s(out1, 16'sd350);
    chk_s(out2, 16'sd350);
  endtask
  task automatic t_man_irq();
    wr(PLC_IRQ_STAT, 32'h3);
    wr(PLC_IRQ_MASK, 32'h1);
    wr(PLC_MAN2, 32'h456);
    wr(PLC_CTRL, 32'h1);
    run(16'sd0, 16'sd0);
    chk_v({out1, out2}, 32'h01230456);
    repeat (3) @(posedge clock);
    chk_v(irq, 1);
    wr(PLC_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clock);
    chk_v(irq, 0);
    wr(PLC_IRQ_MASK, 32'h1);
    wr(PLC_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clock);
    chk_v(irq, 0);
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_empty();
    t_curve();
    t_mono();
    t_man_irq();
    complete_run();
  end
endmodule // tb

// ===== rtl/plc_characterizer.sv
// plc_characterizer: two-channel piecewise-linear characterizer with
// its curve tables, mode, error flag and interrupt in a register file.
// assumes samples and strobes from same-clock logic, one run at a time.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module plc_characterizer #(
  parameter int W = plc_pkg::PLC_W,
  parameter int NPTS = plc_pkg::PLC_NPTS,
  parameter int FRAC = plc_pkg::PLC_FRAC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [plc_pkg::PLC_AW-1:0] reg_addr,
  input wire logic [plc_pkg::PLC_DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [plc_pkg::PLC_DW-1:0] reg_rdata,
  output logic irq,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in1,
  input wire logic signed [W-1:0] in2,
  output logic in_ready,
  output logic signed [W-1:0] out1,
  output logic signed [W-1:0] out2,
  output logic out_valid,
  output logic [1:0] mode,
  output logic cfg_err
);
  import plc_pkg::*;

  // ==========================================================
  // widths and special values
  localparam int NUMW = W + 1 + FRAC;    // scaled rise
  localparam int DENW = W + 1;           // run
  localparam int PW = NUMW + W + 1;      // product width
  localparam logic signed [W-1:0] PINF = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] NINF = {1'b1, {(W-1){1'b0}}};
  localparam logic [4:0] LAST = 5'(NPTS - 1);

  // ==========================================================
  // helpers
  // table index of an address inside a table window, or 5'h1f
  function automatic logic [4:0] tab_idx(input logic [7:0] a,
                                         input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    tab_idx = (a >= base && a[1:0] == 2'b00 && d[7:2] < 6'(NPTS))
              ? d[6:2] : 5'h1f;
  endfunction

  // saturate a wide value to the sample range
  function automatic logic signed [W-1:0] sat(input logic signed [PW-1:0] v);
    if (v > PW'(PINF))
      sat = PINF;
    else if (v < PW'(NINF))
      sat = NINF;
    else
      sat = v[W-1:0];
  endfunction

  // ==========================================================
  // register file state
  logic signed [W-1:0] curve_x [NPTS];   // abscissa table
  logic signed [W-1:0] curve_y [NPTS];   // ordinate table
  logic signed [W-1:0] next_curve_x [NPTS];
  logic signed [W-1:0] next_curve_y [NPTS];
  logic [1:0] mode_req;                  // mode software asks for
  logic swap;                            // inverse selector
  logic [1:0] irq_stat;                  // sticky events
  logic [1:0] irq_mask;
  logic signed [W-1:0] man1, man2;       // manual output values
  logic [1:0] next_mode_req;
  logic next_swap;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  logic signed [W-1:0] next_man1, next_man2;
  logic [PLC_DW-1:0] next_rdata;
  logic next_irq;

  // ==========================================================
  // engine state
  plc_state_t state, next_state;
  logic [4:0] idx, next_idx;             // table walk position
  logic [4:0] npts, next_npts;           // valid points found
  logic ended, next_ended;               // end marker seen
  logic bad, next_bad;                   // config fault found
  logic ydir, next_ydir;                 // y table rising
  logic ch, next_ch;                     // channel being worked
  logic signed [W-1:0] cap1, cap2;       // captured inputs
  logic signed [W-1:0] next_cap1, next_cap2;
  logic signed [W-1:0] seg_k0, next_seg_k0;   // segment start key
  logic signed [W-1:0] seg_o0, next_seg_o0;   // segment start value
  logic signed [NUMW-1:0] slope, next_slope;
  logic signed [PW-1:0] offset, next_offset;
  logic signed [W-1:0] res1, next_res1;
  logic signed [W-1:0] res2, next_res2;
  logic signed [W-1:0] next_out1, next_out2;
  logic next_out_valid, next_in_ready, next_cfg_err;
  logic [1:0] next_mode;
  logic ev_done, ev_err;                 // one-cycle events
  logic div_start;
  logic signed [NUMW-1:0] div_num;
  logic signed [DENW-1:0] div_den;
  logic div_done;
  logic signed [NUMW-1:0] div_quo;

  // ==========================================================
  // slope divider
  plc_divider #(.NW(NUMW), .DW(DENW)) u_div (
    .clock(clock),
    .srst(srst),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  // ==========================================================
  // engine next state
  always_comb
  begin
    logic signed [W-1:0] xi, yi, key, ki, kn, oi, on;
    logic up;
    logic signed [PW-1:0] prod;
    xi = curve_x[idx];
    yi = curve_y[idx];
    // keys come from y only for channel two with inverse on
    key = ch ? cap2 : cap1;
    up = !(ch && swap) || ydir;
    ki = (ch && swap) ? curve_y[idx] : curve_x[idx];           // RULE_04
    oi = (ch && swap) ? curve_x[idx] : curve_y[idx];           // RULE_05
    kn = (ch && swap) ? curve_y[idx + 5'h01] : curve_x[idx + 5'h01];
    on = (ch && swap) ? curve_x[idx + 5'h01] : curve_y[idx + 5'h01];
    prod = '0;
    next_state = state;
    next_idx = idx;
    next_npts = npts;
    next_ended = ended;
    next_bad = bad;
    next_ydir = ydir;
    next_ch = ch;
    next_cap1 = cap1;
    next_cap2 = cap2;
    next_seg_k0 = seg_k0;
    next_seg_o0 = seg_o0;
    next_slope = slope;
    next_offset = offset;
    next_res1 = res1;
    next_res2 = res2;
    next_out1 = out1;
    next_out2 = out2;
    next_out_valid = 1'b0;
    next_in_ready = in_ready;
    next_cfg_err = cfg_err;
    next_mode = mode;
    ev_done = 1'b0;
    ev_err = 1'b0;
    div_start = 1'b0;
    div_num = '0;
    div_den = '0;
    unique case (state)
      PLC_ST_IDLE:
      begin
        // inputs arriving while busy are dropped; in_ready shows it
        if (in_valid)
        begin
          next_cap1 = in1;
          next_cap2 = in2;
          next_idx = 5'h00;
          next_ended = 1'b0;
          next_bad = 1'b0;
          next_npts = 5'(NPTS);
          next_in_ready = 1'b0;
          next_state = PLC_ST_CHECK;
        end
      end
      PLC_ST_CHECK:
      begin
        // check stage: one table point per cycle
        if (xi == NINF || yi == NINF)
          next_bad = 1'b1;                                     // RULE_14
        if (idx == 5'h00 && (xi == PINF || yi == PINF))
          next_bad = 1'b1;                                     // RULE_14
        if (!ended)
        begin
          if (xi == PINF)
          begin
            next_ended = 1'b1;                                 // RULE_07
            next_npts = idx;                                   // RULE_07
          end
          else if (idx != 5'h00)
          begin
            if (xi <= curve_x[idx - 5'h01])
              next_bad = 1'b1;                                 // RULE_14
            if (swap)
            begin
              if (yi == curve_y[idx - 5'h01])
                next_bad = 1'b1;                               // RULE_14
              if (idx == 5'h01)
                next_ydir = yi > curve_y[0];
              else if ((yi > curve_y[idx - 5'h01]) != ydir)
                next_bad = 1'b1;                               // RULE_14
            end
          end
        end
        next_idx = idx + 5'h01;
        if (idx == LAST)
        begin
          // mode is settled before any coefficient work
          next_idx = 5'h00;                                    // RULE_12
          next_ch = 1'b0;
          next_cfg_err = next_bad;                             // RULE_14
          ev_err = next_bad;
          if (next_bad || mode_req == PLC_MODE_OOS || mode_req == 2'b11)
          begin
            next_mode = PLC_MODE_OOS;                          // RULE_14
            next_in_ready = 1'b1;
            next_state = PLC_ST_IDLE;
          end
          else if (mode_req == PLC_MODE_MAN)
          begin
            next_mode = PLC_MODE_MAN;
            next_res1 = man1;
            next_res2 = man2;
            next_state = PLC_ST_FINISH;
          end
          else
          begin
            next_mode = PLC_MODE_AUTO;
            next_state = PLC_ST_SEARCH;                        // RULE_15
          end
        end
      end
      PLC_ST_SEARCH:
      begin
        // walk segments until one brackets the key, or a limit applies
        if (idx == 5'h00 && (up ? key < ki : key > ki))
        begin
          if (ch)
            next_res2 = oi;                                    // RULE_13
          else
            next_res1 = oi;                                    // RULE_11
          next_state = ch ? PLC_ST_FINISH : PLC_ST_SEARCH;
          next_ch = 1'b1;
        end
        else if (idx + 5'h01 >= npts)
        begin
          if (ch)
            next_res2 = oi;                                    // RULE_13
          else
            next_res1 = oi;                                    // RULE_11
          next_idx = 5'h00;
          next_state = ch ? PLC_ST_FINISH : PLC_ST_SEARCH;
          next_ch = 1'b1;
        end
        else if (up ? key <= kn : key >= kn)
        begin
          next_seg_k0 = ki;                                    // RULE_16
          next_seg_o0 = oi;                                    // RULE_16
          div_start = 1'b1;
          div_num = NUMW'(DENW'(on) - DENW'(oi)) <<< FRAC;     // RULE_09
          div_den = DENW'(kn) - DENW'(ki);                     // RULE_09
          next_state = PLC_ST_DIVIDE;
        end
        else
        begin
          next_idx = idx + 5'h01;                              // RULE_16
        end
      end
      PLC_ST_DIVIDE:
      begin
        if (div_done)
        begin
          next_slope = div_quo;                                // RULE_09
          next_state = PLC_ST_COEF;
        end
      end
      PLC_ST_COEF:
      begin
        // offset such that the line passes the segment start point
        prod = PW'(slope) * PW'(seg_k0);
        next_offset = PW'(seg_o0) - (prod >>> FRAC);           // RULE_09
        next_state = PLC_ST_APPLY;
      end
      PLC_ST_APPLY:
      begin
        // truncating scale; error stays under one output step only where the slope is exact
        prod = PW'(slope) * PW'(key);
        if (ch)
          next_res2 = sat((prod >>> FRAC) + offset);           // RULE_10
        else
          next_res1 = sat((prod >>> FRAC) + offset);           // RULE_02
        next_idx = 5'h00;
        next_ch = 1'b1;                                        // RULE_03
        next_state = ch ? PLC_ST_FINISH : PLC_ST_SEARCH;
      end
      PLC_ST_FINISH:
      begin
        next_out1 = res1;
        next_out2 = res2;
        next_out_valid = 1'b1;
        next_in_ready = 1'b1;
        ev_done = 1'b1;
        next_state = PLC_ST_IDLE;
      end
      default:
      begin
        next_state = PLC_ST_IDLE;
        next_in_ready = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // engine registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state <= PLC_ST_IDLE;
      idx <= 5'h00;
      npts <= 5'h00;
      ended <= 1'b0;
      bad <= 1'b0;
      ydir <= 1'b0;
      ch <= 1'b0;
      cap1 <= '0;
      cap2 <= '0;
      seg_k0 <= '0;
      seg_o0 <= '0;
      slope <= '0;
      offset <= '0;
      res1 <= '0;
      res2 <= '0;
      out1 <= '0;
      out2 <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
      cfg_err <= 1'b0;
      mode <= PLC_MODE_OOS;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      npts <= next_npts;
      ended <= next_ended;
      bad <= next_bad;
      ydir <= next_ydir;
      ch <= next_ch;
      cap1 <= next_cap1;
      cap2 <= next_cap2;
      seg_k0 <= next_seg_k0;
      seg_o0 <= next_seg_o0;
      slope <= next_slope;
      offset <= next_offset;
      res1 <= next_res1;
      res2 <= next_res2;
      out1 <= next_out1;
      out2 <= next_out2;
      out_valid <= next_out_valid;
      in_ready <= next_in_ready;
      cfg_err <= next_cfg_err;
      mode <= next_mode;
    end
  end

  // ==========================================================
  // register file next state
  always_comb
  begin
    logic [4:0] xw, yw;
    logic [1:0] clr;
    xw = tab_idx(reg_addr, PLC_X_BASE);
    yw = tab_idx(reg_addr, PLC_Y_BASE);
    clr = 2'h0;
    next_curve_x = curve_x;
    next_curve_y = curve_y;
    next_mode_req = mode_req;
    next_swap = swap;
    next_irq_mask = irq_mask;
    next_man1 = man1;
    next_man2 = man2;
    if (reg_we)
    begin
      // tables are not locked during a run; write between runs
      if (xw != 5'h1f)
        next_curve_x[xw] = reg_wdata[W-1:0];                   // RULE_01
      if (yw != 5'h1f)
        next_curve_y[yw] = reg_wdata[W-1:0];                   // RULE_01
      unique case (reg_addr)
        PLC_CTRL:
        begin
          next_mode_req = reg_wdata[PLC_CTRL_MODE_LSB +: 2];
          next_swap = reg_wdata[PLC_CTRL_SWAP_BIT];
        end
        PLC_IRQ_STAT: clr = reg_wdata[1:0];
        PLC_IRQ_MASK: next_irq_mask = reg_wdata[1:0];
        PLC_MAN1: next_man1 = reg_wdata[W-1:0];
        PLC_MAN2: next_man2 = reg_wdata[W-1:0];
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_irq_stat = (irq_stat & ~clr) | {ev_err, ev_done};
    next_irq = |(next_irq_stat & next_irq_mask);
    next_rdata = '0;
    if (reg_re)
    begin
      if (xw != 5'h1f)
        next_rdata = PLC_DW'(unsigned'(curve_x[xw]));
      else if (yw != 5'h1f)
        next_rdata = PLC_DW'(unsigned'(curve_y[yw]));
      else
        unique case (reg_addr)
          PLC_CTRL: next_rdata = PLC_DW'({swap, mode_req});
          PLC_STATUS: next_rdata = PLC_DW'({in_ready == 1'b0, cfg_err,
                                            mode});
          PLC_IRQ_STAT: next_rdata = PLC_DW'(irq_stat);
          PLC_IRQ_MASK: next_rdata = PLC_DW'(irq_mask);
          PLC_MAN1: next_rdata = PLC_DW'(unsigned'(man1));
          PLC_MAN2: next_rdata = PLC_DW'(unsigned'(man2));
          default: next_rdata = '0;
        endcase
    end
  end

  // ==========================================================
  // register file registers; unused points start at plus infinity
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < NPTS; i++)
      begin
        curve_x[i] <= PINF;
        curve_y[i] <= PINF;
      end
      mode_req <= PLC_CTRL_RST[1:0];
      swap <= PLC_CTRL_RST[2];
      irq_stat <= PLC_IRQ_RST;
      irq_mask <= PLC_IRQ_RST;
      man1 <= '0;
      man2 <= '0;
      reg_rdata <= '0;
      irq <= 1'b0;
    end
    else
    begin
      curve_x <= next_curve_x;
      curve_y <= next_curve_y;
      mode_req <= next_mode_req;
      swap <= next_swap;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      man1 <= next_man1;
      man2 <= next_man2;
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end

endmodule // plc_characterizer

// ===== rtl/plc_divider.sv
// plc_divider: serial signed divider, one quotient bit per clock.
// assumes a nonzero divisor and a start pulse only while idle.
`timescale 1ns/1ps
module plc_divider #(
  parameter int NW = 25,   // dividend and quotient width
  parameter int DW = 17    // divisor width
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic signed [NW-1:0] num,
  input wire logic signed [DW-1:0] den,
  output logic done,
  output logic signed [NW-1:0] quo
);

  // ==========================================================
  // state
  logic [NW-1:0] q;          // quotient magnitude being built
  logic [DW:0] rem;          // partial remainder
  logic [DW-1:0] dmag;       // divisor magnitude
  logic neg;                 // result sign
  logic [5:0] cnt;           // bits still to produce
  logic [NW-1:0] next_q;
  logic [DW:0] next_rem;
  logic [DW-1:0] next_dmag;
  logic next_neg;
  logic [5:0] next_cnt;
  logic next_done;
  logic signed [NW-1:0] next_quo;

  // ==========================================================
  // next state: restoring division on magnitudes
  always_comb
  begin
    logic [DW:0] sh;
    sh = {rem[DW-1:0], q[NW-1]};
    next_q = q;
    next_rem = rem;
    next_dmag = dmag;
    next_neg = neg;
    next_cnt = cnt;
    next_done = 1'b0;
    next_quo = quo;
    if (start)
    begin
      // magnitudes keep the loop unsigned; the sign is fixed at the end
      next_q = num[NW-1] ? NW'(-num) : num;
      next_dmag = den[DW-1] ? DW'(-den) : den;
      next_neg = num[NW-1] ^ den[DW-1];
      next_rem = '0;
      next_cnt = 6'(NW);
    end
    else if (cnt != 6'h00)
    begin
      next_q = {q[NW-2:0], 1'b0};
      if (sh >= {1'b0, dmag})
      begin
        next_rem = sh - {1'b0, dmag};
        next_q[0] = 1'b1;
      end
      else
      begin
        next_rem = sh;
      end
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h01)
      begin
        // last bit: publish the signed quotient with a done pulse
        next_done = 1'b1;
        next_quo = neg ? NW'(-next_q) : next_q;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q <= '0;
      rem <= '0;
      dmag <= '0;
      neg <= 1'b0;
      cnt <= 6'h00;
      done <= 1'b0;
      quo <= '0;
    end
    else
    begin
      q <= next_q;
      rem <= next_rem;
      dmag <= next_dmag;
      neg <= next_neg;
      cnt <= next_cnt;
      done <= next_done;
      quo <= next_quo;
    end
  end

endmodule // plc_divider

// ===== rtl/plc_pkg.sv
// plc_pkg: constants, register map and types of the piecewise-linear
// characterizer. assumes one 40 MHz clock and a plain register port.
//
// Notes on behaviour
// [RULE_01] curve from up to 21 points, linear segments
// [RULE_02] channel one: input is x, output is y
// [RULE_03] inverse off: channel two uses forward curve
// [RULE_04] inverse on: channel two input searched in y
// [RULE_05] inverse on: channel two outputs matching x
// [RULE_06] host keeps x table strictly increasing
// [RULE_07] plus infinity marks unused points, ends curve
// [RULE_08] inverse on: host keeps y table monotone
// [RULE_09] slope and offset derived from tables, selector
// [RULE_10] output equals input times slope plus offset
// [RULE_11] out of span input gives limit value
// [RULE_12] mode and error check precede any computation
// [RULE_13] clamp below first, above last valid point
// [RULE_14] bad curve sets error, forces out of service
// [RULE_15] coefficients computed only in auto, no error
// [RULE_16] segment bracketing the lookup value is used
package plc_pkg;

  // ==========================================================
  // sizes
  localparam int PLC_W = 16;        // sample width, signed
  localparam int PLC_NPTS = 21;     // points of the curve
  localparam int PLC_FRAC = 8;      // fraction bits of the slope
  localparam int PLC_AW = 8;        // register address width
  localparam int PLC_DW = 32;       // register data width

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] PLC_CTRL = 8'h00;     // mode request, inverse
  localparam logic [7:0] PLC_STATUS = 8'h04;   // mode, error, busy
  localparam logic [7:0] PLC_IRQ_STAT = 8'h08; // sticky events, w1c
  localparam logic [7:0] PLC_IRQ_MASK = 8'h0c; // event enables
  localparam logic [7:0] PLC_MAN1 = 8'h10;     // manual value, output 1
  localparam logic [7:0] PLC_MAN2 = 8'h14;     // manual value, output 2
  localparam logic [7:0] PLC_X_BASE = 8'h40;   // x table, one word each
  localparam logic [7:0] PLC_Y_BASE = 8'ha0;   // y table, one word each

  // ==========================================================
  // field positions and reset values
  localparam int PLC_CTRL_MODE_LSB = 0;   // two bits
  localparam int PLC_CTRL_SWAP_BIT = 2;
  localparam int PLC_STAT_MODE_LSB = 0;   // two bits
  localparam int PLC_STAT_ERR_BIT = 2;
  localparam int PLC_STAT_BUSY_BIT = 3;
  localparam int PLC_IRQ_DONE_BIT = 0;
  localparam int PLC_IRQ_ERR_BIT = 1;
  localparam logic [1:0] PLC_IRQ_RST = 2'h0;
  localparam logic [2:0] PLC_CTRL_RST = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PLC_MODE_OOS = 2'b00,
    PLC_MODE_MAN = 2'b01,
    PLC_MODE_AUTO = 2'b10
  } plc_mode_t;

  typedef enum logic [2:0] {
    PLC_ST_IDLE = 3'b000,
    PLC_ST_CHECK = 3'b001,
    PLC_ST_SEARCH = 3'b010,
    PLC_ST_DIVIDE = 3'b011,
    PLC_ST_COEF = 3'b100,
    PLC_ST_APPLY = 3'b101,
    PLC_ST_FINISH = 3'b110
  } plc_state_t;

endpackage
